// ---- atfw_map.vh ----
// register offsets, field positions and codes of the async transmit fifo write port
`ifndef ATFW_MAP_VH
`define ATFW_MAP_VH
// host bus register offsets
`define ATFW_OFS_ACK_LOG     8'h48
`define ATFW_OFS_FIRST       8'h80
`define ATFW_OFS_CONTINUE    8'h84
`define ATFW_OFS_COMMIT      8'h8C
`define ATFW_OFS_WHOLE       8'hA0
// ack log readout field positions
`define ATFW_CNT_LSB         0
`define ATFW_CNT_MSB         2
`define ATFW_TCODE_LSB       4
`define ATFW_TCODE_MSB       7
`define ATFW_LABEL_LSB       8
`define ATFW_LABEL_MSB       15
`define ATFW_NODE_LSB        16
`define ATFW_NODE_MSB        21
`define ATFW_ACK_LSB         24
`define ATFW_ACK_MSB         27
`define ATFW_ERR_BIT         28
// reset values
`define ATFW_ACK_LOG_RST     32'h00000000
`define ATFW_TX_ACK_RST      5'h00
// codes
`define ATFW_ACK_TIMEOUT     5'h10
`define ATFW_ACK_COMPLETE    4'h1
`define ATFW_TCODE_STREAM    4'hA
`define ATFW_NODE_BCAST      6'h3F
`define ATFW_LOG_DEPTH       6
`endif

// ---- atfw_ack_log.v ----
// six-entry acknowledge log, oldest at index zero, drops oldest when full
`timescale 1ns/1ps
module atfw_ack_log #(
    parameter DEPTH = 6,
    parameter W     = 25,
    parameter CW    = 3
) (
    // clock and reset
    input  wire          clk,
    input  wire          rst_n,
    // fill side
    input  wire          push,
    input  wire [W-1:0]  push_data,
    // drain side
    input  wire          pop,
    output wire [W-1:0]  head,
    output reg  [CW-1:0] count
);
    reg [W-1:0] mem [0:DEPTH-1];
    integer     i;
    wire        do_pop  = pop && (count != {CW{1'b0}});
    wire        full    = (count == DEPTH[CW-1:0]);
    // a shift happens on a pop, or on a push that overruns a full log
    wire        shift   = do_pop || (push && full);

    assign head = mem[0];

    // shift-down store; simple because depth is tiny
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {W{1'b0}};
            end
            count <= {CW{1'b0}};
        end else begin
            if (shift) begin
                for (i = 0; i < DEPTH - 1; i = i + 1) begin
                    mem[i] <= mem[i + 1];
                end
                mem[DEPTH-1] <= {W{1'b0}};
            end
            if (push) begin
                if (shift) begin
                    mem[count - 1'b1] <= push_data;
                end else begin
                    mem[count] <= push_data;
                end
            end
            if (push && !shift) begin
                count <= count + 1'b1;
            end else if (do_pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// ---- atfw_port.v ----
// host write port of the async transmit fifo with commit, error and ack logging
`timescale 1ns/1ps
`include "atfw_map.vh"
module atfw_port #(
    parameter AW = 6
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // host bus, synchronous to clk
    input  wire        cs_n,
    input  wire        wr_n,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    output reg  [31:0] rdata,
    output reg         cycle_ack_n,
    // transmitter side
    input  wire        tx_rd,
    output reg         tx_avail,
    output reg  [32:0] tx_quad,
    input  wire        tx_sent,
    input  wire        arb_timeout,
    output reg         arb_request,
    // acknowledge capture
    input  wire        ack_in_valid,
    input  wire [3:0]  ack_in_code,
    input  wire        ack_in_err,
    input  wire        ack_timeout,
    output reg  [4:0]  transmit_ack_field,
    // control and status
    input  wire        async_fifo_clear,
    input  wire        transmit_ready_clear,
    output reg         async_fifo_empty_flag,
    output reg         transmit_ready_irq,
    output reg         ack_valid_flag,
    output reg         async_bad_packet_irq,
    output reg         async_send_allowed
);
    // fifo depth in quadlets; fill has one extra bit so that full is visible
    localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

    // storage and the write, read and release pointers, all wrapping together
    reg  [32:0]   mem [0:(1<<AW)-1];
    reg  [AW-1:0] wptr;
    reg  [AW-1:0] rptr;
    reg  [AW-1:0] rel_ptr;
    reg  [AW:0]   fill;
    // packet framing
    reg           pkt_open;
    reg           burst_act;
    // host select of the previous clock
    reg           cs_q_n;
    reg  [31:0]   cur_first;

    // ack log head entry and its count
    wire [24:0]   log_head;
    wire [2:0]    log_count;

    // host cycle decode
    wire wr_cyc     = !cs_n && !wr_n;
    // each write window is a full byte offset match
    wire hit_first  = wr_cyc && (addr == `ATFW_OFS_FIRST);
    wire hit_cont   = wr_cyc && (addr == `ATFW_OFS_CONTINUE);
    wire hit_commit = wr_cyc && (addr == `ATFW_OFS_COMMIT);
    wire hit_whole  = wr_cyc && (addr == `ATFW_OFS_WHOLE);

    // a read starts on the first select cycle, so a long select pops the log once
    wire rd_start   = !cs_n && wr_n && cs_q_n;
    wire log_pop    = rd_start && (addr == `ATFW_OFS_ACK_LOG);

    wire bad_first  = (hit_cont || hit_commit) && !pkt_open;
    // transmitter drained past what the host supplied
    wire underflow  = tx_rd && !tx_avail;
    // a clear in the same cycle wins over a new error
    wire go_bad     = (bad_first || underflow) && !async_fifo_clear;

    // writes while full or in bad state are dropped; no wait state exists to stall the host
    wire room       = (fill != DEPTH);
    // every window pushes; the address only picks control bit and commit
    wire any_hit    = hit_first || hit_cont || hit_commit || hit_whole;
    wire do_push    = any_hit && room && async_send_allowed && !bad_first;
    // control bit one for 80h and the opening A0h quadlet
    wire ctrl_bit   = hit_first || (hit_whole && !burst_act);

    // burst ends when select leaves A0h, which commits
    wire burst_end  = burst_act && !hit_whole;
    // continue-update commits including the word just written
    wire commit     = (hit_commit && do_push) || burst_end;

    // a pop needs a released word; a pop without one is an underflow
    wire do_pop     = tx_rd && tx_avail;
    // write pointer after this push, wrapping with the fifo
    wire [AW-1:0] wptr_inc = wptr + 1'b1;

    // only words below the release pointer are visible
    wire [AW-1:0] next_rel   = (hit_commit && do_push) ? wptr_inc : wptr;
    // read pointer one pop ahead
    wire [AW-1:0] next_rptr  = do_pop ? rptr + 1'b1 : rptr;
    // a commit in this cycle counts at once, so the word can leave next clock
    wire [AW-1:0] rel_eff    = commit ? next_rel : rel_ptr;
    wire          next_avail = (next_rptr != rel_eff) && !go_bad && async_send_allowed
                               && !async_fifo_clear;

    // streaming and broadcast packets expect no remote ack
    wire no_ack_pkt = (cur_first[`ATFW_TCODE_MSB:`ATFW_TCODE_LSB] == `ATFW_TCODE_STREAM)
                   || (cur_first[`ATFW_NODE_MSB:`ATFW_NODE_LSB] == `ATFW_NODE_BCAST);
    // no remote ack comes for these, so the send itself logs an entry
    wire stream_done = tx_sent && no_ack_pkt;
    // only the first ack of a transmit-ready period is taken
    wire ack_take    = ack_in_valid && !ack_valid_flag && !no_ack_pkt;
    // each logged entry also sets ack-valid, and the ack field unless a timeout comes in the same cycle
    wire log_push    = ack_take || stream_done;
    wire [3:0] log_code = stream_done ? `ATFW_ACK_COMPLETE : ack_in_code;
    wire       log_err  = stream_done ? 1'b0 : ack_in_err;
    wire [24:0] log_entry = {log_err, log_code, 2'b00,
                             cur_first[`ATFW_NODE_MSB:`ATFW_NODE_LSB],
                             cur_first[`ATFW_LABEL_MSB:`ATFW_LABEL_LSB],
                             cur_first[`ATFW_TCODE_MSB:`ATFW_TCODE_LSB]};
    // count in the low bits, bit 3 reads zero
    wire [31:0] log_readout = {3'b000, log_head, 1'b0, log_count};

    // fifo storage has no reset; pointers alone define its content
    always @(posedge clk) begin
        if (do_push) begin
            // quadlet captured on every edge with an accepted write (do_push)
            mem[wptr] <= {ctrl_bit, wdata};
        end
    end

    // pointers, fill level and packet framing
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr      <= {AW{1'b0}};
            rptr      <= {AW{1'b0}};
            rel_ptr   <= {AW{1'b0}};
            fill      <= {(AW+1){1'b0}};
            pkt_open  <= 1'b0;
            burst_act <= 1'b0;
            tx_avail  <= 1'b0;
            tx_quad   <= 33'h000000000;
            cur_first <= 32'h00000000;
        end else if (async_fifo_clear) begin
            wptr      <= {AW{1'b0}};
            rptr      <= {AW{1'b0}};
            rel_ptr   <= {AW{1'b0}};
            fill      <= {(AW+1){1'b0}};
            pkt_open  <= 1'b0;
            burst_act <= 1'b0;
            tx_avail  <= 1'b0;
        end else begin
            if (do_push) begin
                wptr <= wptr_inc;
            end
            // read pointer follows every pop
            rptr <= next_rptr;
            if (commit) begin
                rel_ptr <= next_rel;
            end
            // fill guards the write side only; push and pop together leave it
            fill <= fill + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
            // continue writes leave the packet open and unreleased
            if (hit_first || (hit_whole && !burst_act)) begin
                pkt_open <= 1'b1;
            end else if (burst_end || go_bad) begin
                pkt_open <= 1'b0;
            end
            // a gap in select ends the burst
            burst_act <= hit_whole && async_send_allowed;
            // release shows one clock after the commit, never earlier
            tx_avail  <= next_avail;
            if (do_pop) begin
                tx_quad <= mem[rptr];
                // header fields of a first quadlet feed the ack log entry
                if (mem[rptr][32]) begin
                    cur_first <= mem[rptr][31:0];
                end
            end
        end
    end

    // bad state holds async traffic off until fifo clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            async_bad_packet_irq <= 1'b0;
            async_send_allowed   <= 1'b1;
        end else if (async_fifo_clear) begin
            async_bad_packet_irq <= 1'b0;
            async_send_allowed   <= 1'b1;
        end else if (go_bad) begin
            async_bad_packet_irq <= 1'b1;
            async_send_allowed   <= 1'b0;
        end
    end

    // empty flag, arbitration request and transmit-ready
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            async_fifo_empty_flag <= 1'b1;
            arb_request           <= 1'b0;
            transmit_ready_irq    <= 1'b0;
        end else begin
            // commit on empty clears flag and requests bus
            arb_request <= commit && async_fifo_empty_flag;
            // the send test further down is later, so a send in the same cycle wins
            if (commit && async_fifo_empty_flag) begin
                async_fifo_empty_flag <= 1'b0;
            end
            // sent sets empty, arbitration timeout leaves it zero
            if (tx_sent || async_fifo_clear) begin
                async_fifo_empty_flag <= 1'b1;
            end
            // set wins over a clear in the same cycle
            if (tx_sent || arb_timeout) begin
                transmit_ready_irq <= 1'b1;
            end else if (transmit_ready_clear) begin
                transmit_ready_irq <= 1'b0;
            end
        end
    end

    // ack-valid flag and transmit ack field
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_valid_flag     <= 1'b0;
            transmit_ack_field <= `ATFW_TX_ACK_RST;
        end else begin
            // only one ack captured per transmit-ready period
            if (log_push) begin
                ack_valid_flag <= 1'b1;
            end else if (transmit_ready_clear) begin
                ack_valid_flag <= 1'b0;
            end
            // timeout overrides with the no-response code
            if (ack_timeout) begin
                transmit_ack_field <= `ATFW_ACK_TIMEOUT;
            end else if (log_push) begin
                transmit_ack_field <= {1'b0, log_code};
            end
        end
    end

    // host read data and cycle acknowledge, one cycle behind select
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_q_n      <= 1'b1;
            cycle_ack_n <= 1'b1;
            rdata       <= `ATFW_ACK_LOG_RST;
        end else begin
            // select of the previous clock marks the first cycle of a read
            cs_q_n      <= cs_n;
            // acknowledge trails select by one clock
            cycle_ack_n <= cs_n;
            // value sampled before the pop takes effect
            if (log_pop) begin
                rdata <= log_readout;
            end else if (rd_start) begin
                rdata <= 32'h00000000;
            end
        end
    end

    // six-entry ack log, read pops, full drops oldest
    atfw_ack_log #(
        .DEPTH (`ATFW_LOG_DEPTH),
        .W     (25),
        .CW    (3)
    ) u_ack_log (
        .clk       (clk),
        .rst_n     (rst_n),
        .push      (log_push),
        .push_data (log_entry),
        .pop       (log_pop),
        .head      (log_head),
        .count     (log_count)
    );
endmodule

// ---- atfw_checker.sv ----
// concurrent checks on the async transmit fifo write port
`timescale 1ns/1ps
module atfw_checker (
    // clock and reset
    input logic       clk,
    input logic       rst_n,
    // host bus
    input logic       cs_n,
    input logic       wr_n,
    input logic [7:0] addr,
    input logic       cycle_ack_n,
    // transmitter and acknowledge side
    input logic       tx_rd,
    input logic       tx_avail,
    input logic       tx_sent,
    input logic       arb_timeout,
    input logic       arb_request,
    input logic       ack_in_valid,
    input logic       ack_timeout,
    input logic [4:0] transmit_ack_field,
    // control and status
    input logic       async_fifo_clear,
    input logic       transmit_ready_clear,
    input logic       async_fifo_empty_flag,
    input logic       transmit_ready_irq,
    input logic       ack_valid_flag,
    input logic       async_bad_packet_irq,
    input logic       async_send_allowed
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a host write into one window, and the idle state in which a commit must start arbitration
    sequence s_wr(a); !cs_n && !wr_n && addr == a; endsequence
    sequence s_idle; async_fifo_empty_flag && async_send_allowed && !tx_sent && !async_fifo_clear; endsequence
    property p_ack_low; !cs_n |=> !cycle_ack_n; endproperty
    a_ack_low: assert property (p_ack_low) else $error("cycle ack not low after select");
    property p_ack_high; $rose(cs_n) |=> cycle_ack_n; endproperty
    a_ack_high: assert property (p_ack_high) else $error("cycle ack held after release");
    property p_commit; (s_wr(8'h8C) and s_idle) |=> arb_request || async_bad_packet_irq; endproperty
    a_commit: assert property (p_commit) else $error("commit gave no arbitration request");
    property p_burst; (s_wr(8'hA0) and s_idle) ##1 (cs_n && !tx_sent) |=> arb_request; endproperty
    a_burst: assert property (p_burst) else $error("burst end gave no arbitration request");
    property p_ready; tx_sent || arb_timeout |=> transmit_ready_irq; endproperty
    a_ready: assert property (p_ready) else $error("transmit ready not set");
    property p_sent; tx_sent |=> async_fifo_empty_flag; endproperty
    a_sent: assert property (p_sent) else $error("empty flag not set after send");
    property p_tmo; ack_timeout |=> transmit_ack_field == 5'h10; endproperty
    a_tmo: assert property (p_tmo) else $error("timeout code not reported");
    property p_ack_valid_flag; ack_in_valid |=> ack_valid_flag; endproperty
    a_ack_valid_flag: assert property (p_ack_valid_flag) else $error("ack valid not set");
    property p_uflow; tx_rd && !tx_avail && !async_fifo_clear |=> async_bad_packet_irq && !async_send_allowed; endproperty
    a_uflow: assert property (p_uflow) else $error("underflow did not enter bad state");
    property p_block; async_bad_packet_irq [*2] |-> !tx_avail; endproperty
    a_block: assert property (p_block) else $error("words offered in bad state");
    property p_clear; async_fifo_clear |=> !async_bad_packet_irq && async_fifo_empty_flag; endproperty
    a_clear: assert property (p_clear) else $error("fifo clear did not recover");
endmodule
bind atfw_port atfw_checker u_chk (.*);

// ---- atfw_tx_model.sv ----
// transmitter stand-in: pops released words and keeps them for comparison
`timescale 1ns/1ps
module atfw_tx_model (
    // clock and reset
    input  logic        clk,
    input  logic        rst_n,
    // bench control, forces one pop to provoke an underflow
    input  logic        force_rd,
    // transmit fifo read side
    input  logic        tx_avail,
    input  logic [32:0] tx_quad,
    output logic        tx_rd,
    // captured words
    output logic [32:0] got [0:63],
    output int          n_got
);
    logic rd_d;
    // pop then idle one cycle, because tx_avail lags a pop by a cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_rd <= 1'b0;
            rd_d  <= 1'b0;
            n_got <= 0;
        end else begin
            tx_rd <= force_rd | (tx_avail & ~tx_rd);
            rd_d  <= tx_rd & tx_avail;
            if (rd_d) begin
                got[n_got] <= tx_quad;
                n_got      <= n_got + 1;
            end
        end
    end
endmodule

// ---- tb.sv ----
// self-checking bench for the async transmit fifo write port
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, cs_n, wr_n, cycle_ack_n, tx_rd, tx_avail, tx_sent, arb_timeout;
    logic arb_request, ack_in_valid, ack_in_err, ack_timeout, async_fifo_clear, force_rd;
    logic transmit_ready_clear, async_fifo_empty_flag, transmit_ready_irq, ack_valid_flag;
    logic async_bad_packet_irq, async_send_allowed;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [32:0] tx_quad;
    logic [32:0] got [0:63];
    logic [32:0] eq [$];
    logic [4:0]  transmit_ack_field;
    logic [3:0]  ack_in_code;
    int          n_got, fails, n_checks, base, k, i;
    atfw_port #(.AW(3)) u_dut (.*);
    atfw_tx_model u_tx (.*);
    // free running clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input logic [32:0] ev, input logic [32:0] sv);
        n_checks++;
        if (sv !== ev) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ev, sv);
        end
    endtask
    // one write beat; the caller keeps select low for back to back beats
    task wrq(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        eq.push_back({a == 8'h80 || (a == 8'hA0 && cs_n), d});
        cs_n  <= 1'b0;
        wr_n  <= 1'b0;
        addr  <= a;
        wdata <= d;
    endtask
    task idle;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // read holds select one clock past the edge where the cycle ack is seen low
    task rd(input logic [7:0] a, input logic [31:0] ev, input string nm);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b1;
        addr <= a;
        @(posedge clk);
        #1;
        chk(nm, {1'b0, ev}, {cycle_ack_n, rdata});
        @(posedge clk);
        cs_n <= 1'b1;
    endtask
    // one-cycle pulse on a status input picked by index
    task strobe(input int s);
        @(posedge clk);
        {transmit_ready_clear, async_fifo_clear, ack_timeout, ack_in_valid, arb_timeout,
            tx_sent} <= 6'h01 << s;
        @(posedge clk);
        {transmit_ready_clear, async_fifo_clear, ack_timeout, ack_in_valid, arb_timeout,
            tx_sent} <= 6'h00;
        @(posedge clk);
        #1;
    endtask
    // bounded wait for the transmitter, then compare in write order
    task drain(input int n);
        for (i = 0; i < 60 && n_got < base + n; i++) @(posedge clk);
        if (n_got < base + n) begin
            fails++;
            $display("CHECK FAILED drain expected %0d seen %0d", base + n, n_got);
            close_out();
        end
        repeat (n) begin
            chk("quad", eq.pop_front(), got[base]);
            base++;
        end
    endtask
    function logic [31:0] entry(input int p, input logic [2:0] c);
        entry = {3'h0, p[0], p[3:0] + 4'h2, 2'h0, 6'h05, p[7:0] + 8'h10, 4'h1, 1'b0, c};
    endfunction
    initial begin
        {rst_n, cs_n, wr_n, addr, wdata, ack_in_code, ack_in_err, force_rd} = 0;
        {transmit_ready_clear, async_fifo_clear, ack_timeout, ack_in_valid, arb_timeout,
            tx_sent} = 6'h00;
        cs_n = 1'b1;
        wr_n = 1'b1;
        base = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h48, 32'h0000_0000, "log_reset");
        rd(8'h44, 32'h0000_0000, "unmapped");
        // seven packets through first, continue and commit windows
        for (k = 0; k < 7; k++) begin
            q = {10'h000, 6'h05, k[7:0] + 8'h10, 4'h1, 4'h0};
            wrq(8'h80, q);
            wrq(8'h84, ~q);
            idle();
            chk("held", 33'h0, tx_avail);
            wrq(8'h84, q + 1);
            wrq(8'h8C, q + 2);
            idle();
            drain(4);
            chk("armed", 33'h0, async_fifo_empty_flag);
            if (k == 0) begin
                strobe(1);
                chk("rearb", 33'h0, {async_fifo_empty_flag, !transmit_ready_irq});
                strobe(5);
            end
            ack_in_code <= k[3:0] + 4'h2;
            ack_in_err  <= k[0];
            strobe(2);
            chk("ack", {28'h2, k[3:0] + 4'h2}, {ack_valid_flag, transmit_ack_field});
            strobe(0);
            chk("sent", 33'h3, {async_fifo_empty_flag, transmit_ready_irq});
            strobe(5);
            chk("ready_clr", 33'h0, {ack_valid_flag, transmit_ready_irq});
        end
        for (k = 0; k < 6; k++) rd(8'h48, entry(k + 1, 3'd6 - k[2:0]), "log");
        $display("test packets done");
        // whole packet through the burst window, streaming code
        q = {10'h000, 6'h3F, 8'h77, 4'hA, 4'h0};
        wrq(8'hA0, q);
        wrq(8'hA0, q + 1);
        wrq(8'hA0, q + 2);
        idle();
        drain(3);
        strobe(0);
        rd(8'h48, {4'h0, 4'h1, 2'h0, 6'h3F, 8'h77, 4'hA, 4'h1}, "stream");
        strobe(5);
        strobe(3);
        chk("timeout", 33'h10, transmit_ack_field);
        $display("test burst done");
        // continue write with no open packet, then an underflow
        wrq(8'h84, 32'h0000_0001);
        idle();
        chk("bad", 33'h1, {async_send_allowed, async_bad_packet_irq});
        wrq(8'h80, q);
        wrq(8'h8C, q);
        idle();
        chk("blocked", 33'h0, tx_avail);
        strobe(4);
        chk("clear", 33'h6, {async_send_allowed, async_fifo_empty_flag, async_bad_packet_irq});
        eq.delete();
        @(posedge clk);
        force_rd <= 1'b1;
        @(posedge clk);
        force_rd <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("underflow", 33'h1, async_bad_packet_irq);
        strobe(4);
        $display("test errors done");
        close_out();
    end
endmodule
